// file: bench/gpc_mmd_model.sv
// MMD device model behind the indirect access port.
// Assumes one clock and a request held until acknowledged.
`timescale 1ns/1ps
module gpc_mmd_model (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic [3:0]            delay,
  input  wire gpc_pkg::gpc_mmd_req_t req,
  output gpc_pkg::gpc_mmd_rsp_t      rsp
);
  logic [15:0] mem [0:8191];
  logic [3:0]  waitCnt;
  logic [12:0] idx;
  assign idx = {req.dev, req.addr[7:0]};
  initial foreach (mem[i]) mem[i] = 16'h5a5a ^ 16'(i);
  // ==========================================================
  // Answer after delay cycles
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt <= 4'h0;
      rsp     <= '0;
    end else begin
      if (req.valid && !rsp.ack && (waitCnt >= delay)) begin
        waitCnt   <= 4'h0;
        rsp.ack   <= 1'b1;
        rsp.rdata <= req.write ? ~rsp.rdata : mem[idx];
        if (req.write) begin
          mem[idx] <= req.wdata;
        end
      end else begin
        rsp.ack   <= 1'b0;
        rsp.rdata <= ~rsp.rdata;  // No stale data outside ack
        if (req.valid && !rsp.ack) begin
          waitCnt <= waitCnt + 4'h1;
        end
      end
    end
  end
endmodule // gpc_mmd_model

// file: bench/gpc_regs_tb.sv
// Self-checking bench for the gigabit control and MMD register group.
// Assumes gpc_regs, gpc_pkg and gpc_mmd_model compiled before it.
`timescale 1ns/1ps
`include "gpc_consts.svh"
module gpc_regs_tb;
  logic                      clk;
  logic                      rst_b;
  logic                      ce;
  logic [7:0]                address;
  logic                      read;
  logic                      write;
  logic [31:0]               writedata;
  logic [31:0]               readdata;
  logic                      waitrequest;
  logic                      irq;
  logic [3:0]                delay;
  gpc_pkg::gpc_phy_status_t  phyStatus;
  gpc_pkg::gpc_phy_ctrl_t    phyCtrl;
  gpc_pkg::gpc_mmd_req_t     mmdReq;
  gpc_pkg::gpc_mmd_rsp_t     mmdRsp;
  int                        miscompares;
  int                        numChecks;

  gpc_regs #(.DEV_W(5)) DUT (.clk(clk), .rst_b(rst_b), .ce(ce), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(4'h3),
    .readdata(readdata), .waitrequest(waitrequest), .phyStatus(phyStatus),
    .phyCtrl(phyCtrl), .mmdReq(mmdReq), .mmdRsp(mmdRsp), .irq(irq));
  gpc_mmd_model model (.clk(clk), .rst_b(rst_b), .delay(delay), .req(mmdReq), .rsp(mmdRsp));

  // ==========================================================
  // Shared tasks
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task bus(input logic wr, input logic [5:0] idx, input logic [15:0] wd,
           output logic [15:0] rd);
    @(posedge clk);
    address   <= {idx, 2'b00};
    read      <= ~wr;
    write     <= wr;
    writedata <= {16'h0000, wd};
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rd = readdata[15:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task rdc(input logic [5:0] idx, input logic [15:0] exp, input string name);
    logic [15:0] v;
    bus(1'b0, idx, 16'h0000, v);
    check(name, v, exp);
  endtask

  task wrr(input logic [5:0] idx, input logic [15:0] d);
    logic [15:0] v;
    bus(1'b1, idx, d, v);
  endtask

  task pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      phyStatus.rxErrorSym <= 1'b1;
      @(posedge clk);
      phyStatus.rxErrorSym <= 1'b0;
    end
  endtask

  // ==========================================================
  // Scenarios
  task t_reset();
    rdc(`GPC_IDX_CTRL, 16'h0300, "ctrl");
    check("ctrl out", 16'(phyCtrl), 16'h0003);
    rdc(`GPC_IDX_STS, 16'h0000, "status");
    rdc(`GPC_IDX_SETUP, 16'h0000, "setup");
    rdc(`GPC_IDX_DATA, 16'h0000, "data");
    $display("test reset done");
  endtask

  task t_role();
    logic [2:0] i;
    for (int k = 0; k < 8; k++) begin
      i = k[2:0];
      wrr(`GPC_IDX_CTRL, {i, i, i[1:0], 8'hff});
      rdc(`GPC_IDX_CTRL, {i, i, i[1:0], 8'h00}, "ctrl");
      check("ctrl out", 16'(phyCtrl), {9'h0, i, i[2], i[2] ? i[1] : i[0], i[1:0]});
    end
    wrr(`GPC_IDX_CTRL, 16'h0300);
    wrr(`GPC_IDX_CTRL, 16'h0b00);
    check("role value ignored", 16'(phyCtrl), 16'h0003);
    wrr(`GPC_IDX_CTRL, 16'h0300);
    $display("test role done");
  endtask

  task t_status();
    logic [4:0] p;
    for (int k = 0; k < 2; k++) begin
      p = k[0] ? 5'h15 : 5'h0a;
      @(posedge clk);
      {phyStatus.resolvedMaster, phyStatus.localRxOk, phyStatus.remoteRxOk,
       phyStatus.lpFullDuplex, phyStatus.lpHalfDuplex} <= p;
      rdc(`GPC_IDX_STS, {1'b0, p, 10'h000}, "status");
    end
    @(posedge clk);
    phyStatus.msFault <= 1'b1;
    @(posedge clk);
    phyStatus.msFault <= 1'b0;
    rdc(`GPC_IDX_STS, {1'b1, p, 10'h000}, "fault set");
    rdc(`GPC_IDX_STS, {1'b0, p, 10'h000}, "fault clear");
    @(posedge clk);
    phyStatus <= '0;
    $display("test status done");
  endtask

  task t_idle();
    @(posedge clk);
    phyStatus.rxIdle      <= 1'b1;
    phyStatus.txModeSendN <= 1'b1;
    pulses(5);
    phyStatus.txModeSendN <= 1'b0;
    pulses(2);
    phyStatus.rxIdle      <= 1'b0;
    phyStatus.txModeSendN <= 1'b1;
    pulses(2);
    rdc(`GPC_IDX_STS, 16'h0005, "idle count");
    rdc(`GPC_IDX_STS, 16'h0000, "idle clear");
    phyStatus.rxIdle <= 1'b1;
    pulses(300);
    rdc(`GPC_IDX_STS, 16'h00ff, "idle sat");
    $display("test idle done");
  endtask

  task t_irq();
    rdc(`GPC_IDX_IRQ_STS, 16'h0003, "irq status");
    check("irq masked", {15'h0, irq}, 16'h0000);
    wrr(`GPC_IDX_IRQ_MASK, 16'h0002);
    repeat (2) @(posedge clk);
    check("irq raised", {15'h0, irq}, 16'h0001);
    wrr(`GPC_IDX_IRQ_STS, 16'h0002);
    repeat (2) @(posedge clk);
    check("irq cleared", {15'h0, irq}, 16'h0000);
    rdc(`GPC_IDX_IRQ_STS, 16'h0001, "irq status");
    wrr(6'h20, 16'hffff);
    rdc(6'h20, 16'h0000, "unmapped");
    $display("test irq done");
  endtask

  task t_mmd();
    wrr(`GPC_IDX_SETUP, 16'h0003);
    wrr(`GPC_IDX_DATA, 16'h0010);
    rdc(`GPC_IDX_DATA, 16'h0010, "pointer");
    wrr(`GPC_IDX_SETUP, 16'h0004);
    rdc(`GPC_IDX_DATA, 16'h0000, "other dev");
    wrr(`GPC_IDX_SETUP, 16'h4003);
    delay <= 4'h3;
    wrr(`GPC_IDX_DATA, 16'haaaa);
    check("mem 10", model.mem[13'h0310], 16'haaaa);
    rdc(`GPC_IDX_DATA, 16'haaaa, "mode 01");
    wrr(`GPC_IDX_SETUP, 16'h8003);
    rdc(`GPC_IDX_DATA, 16'haaaa, "mode 10");
    wrr(`GPC_IDX_DATA, 16'hbbbb);
    check("mem 11", model.mem[13'h0311], 16'hbbbb);
    delay <= 4'h0;
    wrr(`GPC_IDX_SETUP, 16'hc003);
    rdc(`GPC_IDX_DATA, 16'h5948, "mode 11");
    rdc(`GPC_IDX_DATA, 16'h5948, "mode 11");
    wrr(`GPC_IDX_DATA, 16'hcccc);
    check("mem 12", model.mem[13'h0312], 16'hcccc);
    wrr(`GPC_IDX_SETUP, 16'h0003);
    rdc(`GPC_IDX_DATA, 16'h0013, "pointer end");
    $display("test mmd done");
  endtask

  task t_freeze();
    @(posedge clk);
    ce                <= 1'b0;
    phyStatus.msFault <= 1'b1;
    @(posedge clk);
    phyStatus.msFault <= 1'b0;
    @(posedge clk);
    ce                <= 1'b1;
    rdc(`GPC_IDX_STS, 16'h0000, "frozen fault");
    check("frozen ctrl out", 16'(phyCtrl), 16'h0003);
    $display("test freeze done");
  endtask

  task finish_test();
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock, reset, sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    delay = 4'h0;
    phyStatus = '0;
    miscompares = 0;
    numChecks = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_role();
    t_status();
    t_idle();
    t_irq();
    t_mmd();
    t_freeze();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test();
  end
endmodule // gpc_regs_tb

// file: hdl/gpc_consts.svh
// Constants of the gigabit PHY control register group.
// Assumes inclusion by bare name from the package and the design.
`ifndef GPC_CONSTS_SVH
`define GPC_CONSTS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define GPC_IDX_CTRL     6'h09
`define GPC_IDX_STS      6'h0a
`define GPC_IDX_SETUP    6'h0d
`define GPC_IDX_DATA     6'h0e
`define GPC_IDX_IRQ_STS  6'h10
`define GPC_IDX_IRQ_MASK 6'h11

// ==========================================================
// Reset values and masks
`define GPC_CTRL_RST     16'h0300
`define GPC_CTRL_WMASK   16'hff00
`define GPC_ZERO16       16'h0000
`define GPC_IDLE_MAX     8'hff
`define GPC_IDLE_ONE     8'h01
`define GPC_IDLE_ZERO    8'h00
`define GPC_PTR_ONE      16'h0001

// ==========================================================
// Field positions
`define GPC_B_TEST_HI    15
`define GPC_B_TEST_LO    13
`define GPC_B_MANUAL     12
`define GPC_B_MVAL       11
`define GPC_B_PTYPE      10
`define GPC_B_ADVF       9
`define GPC_B_ADVH       8
`define GPC_B_MODE_HI    15
`define GPC_B_MODE_LO    14
`define GPC_B_DEV_HI     4
`define GPC_B_DEV_LO     0
`define GPC_B_RES        14
`define GPC_B_FAULT      15
`define GPC_B_LRX        13
`define GPC_B_RRX        12
`define GPC_B_LPF        11
`define GPC_B_LPH        10
`define GPC_B_CNT_HI     7
`define GPC_B_CNT_LO     0
`define GPC_IRQ_FAULT    0
`define GPC_IRQ_IDLE     1

// ==========================================================
// Indirect operation modes
`define GPC_MODE_REG     2'h0
`define GPC_MODE_NOINC   2'h1
`define GPC_MODE_INCRW   2'h2
`define GPC_MODE_INCW    2'h3

`endif

// file: hdl/gpc_pkg.sv
// Types of the gigabit PHY control register group.
// Assumes gpc_consts.svh on the include path.
`include "gpc_consts.svh"
package gpc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_MMD  = 2'h1,
    ST_RESP = 2'h3
  } gpc_state_t;

  // Live status from the PHY core, one sample per clock
  typedef struct packed {
    logic msFault;
    logic resolvedMaster;
    logic localRxOk;
    logic remoteRxOk;
    logic lpFullDuplex;
    logic lpHalfDuplex;
    logic rxIdle;
    logic rxErrorSym;
    logic txModeSendN;
  } gpc_phy_status_t;

  // Settings handed to the PHY core
  typedef struct packed {
    logic [2:0] testMode;
    logic       roleManual;
    logic       roleMaster;
    logic       advFull;
    logic       advHalf;
  } gpc_phy_ctrl_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [4:0]  dev;
    logic [15:0] addr;
    logic [15:0] wdata;
  } gpc_mmd_req_t;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } gpc_mmd_rsp_t;
endpackage

// file: hdl/gpc_regs.sv
// Gigabit control/status and indirect MMD access registers, Avalon-MM slave.
// Assumes one clock, PHY status synchronous to clk, MMD devices answer by ack.
//
// Contract
// - Manual role enable bit 12 makes the PHY use the software role.
// - Manual role value bit 11 is ignored while manual enable is clear.
// - With manual enable, value one forces master, zero forces slave.
// - Without manual enable, port type bit 10 gives master or slave preference.
// - Control bit 9, reset one, advertises gigabit full duplex.
// - Control bit 8, reset one, advertises gigabit half duplex.
// - Status bit 15 latches a role fault, clears on read, resets zero.
// - Status bit 14 shows the resolved role, one for master.
// - Status bits 13 and 12 show local and remote receiver OK.
// - Status bits 11 and 10 show partner gigabit full and half duplex.
// - Eight-bit idle error count, clear on read, counts in normal-send idles.
// - The count rises once per symbol period flagged as an error.
// - Setup device field selects the MMD device for mode and data.
// - Mode 00 makes the data register reach the device address pointer.
// - Nonzero modes make the data register reach the addressed data.
// - Mode 01 leaves the address unchanged after data accesses.
// - Mode 10 advances the address after every read and write.
// - Mode 11 advances the address after writes only.
`timescale 1ns/1ps
`include "gpc_consts.svh"

module gpc_regs #(
  parameter int DEV_W = 5
) (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     ce,
  input  wire logic [7:0]               address,
  input  wire logic                     read,
  input  wire logic                     write,
  input  wire logic [31:0]              writedata,
  input  wire logic [3:0]               byteenable,
  output logic      [31:0]              readdata,
  output logic                          waitrequest,
  input  wire gpc_pkg::gpc_phy_status_t phyStatus,
  output gpc_pkg::gpc_phy_ctrl_t        phyCtrl,
  output gpc_pkg::gpc_mmd_req_t         mmdReq,
  input  wire gpc_pkg::gpc_mmd_rsp_t    mmdRsp,
  output logic                          irq
);
  localparam int DEVS = 1 << DEV_W;

  // ==========================================================
  // State
  typedef struct packed {
    gpc_pkg::gpc_state_t      st;
    logic                     waitReq;
    logic [15:0]              rdata;
    logic [15:0]              ctrl;
    logic [15:0]              setup;
    logic [DEVS-1:0][15:0]    ptr;
    logic                     msFault;
    logic [7:0]               idleCnt;
    logic [1:0]               irqSts;
    logic [1:0]               irqMask;
    logic                     irq;
    gpc_pkg::gpc_phy_ctrl_t   phyCtrl;
    gpc_pkg::gpc_mmd_req_t    mmd;
  } gpc_regs_state_t;

  localparam gpc_regs_state_t S_RST = '{
    st:      gpc_pkg::ST_IDLE,
    waitReq: 1'b1,
    rdata:   `GPC_ZERO16,
    ctrl:    `GPC_CTRL_RST,
    setup:   `GPC_ZERO16,
    ptr:     '0,
    msFault: 1'b0,
    idleCnt: '0,
    irqSts:  '0,
    irqMask: '0,
    irq:     1'b0,
    phyCtrl: '{testMode: 3'h0, roleManual: 1'b0, roleMaster: 1'b0,
               advFull: 1'b1, advHalf: 1'b1},
    mmd:     '0
  };

  gpc_regs_state_t s_reg;
  gpc_regs_state_t s_next;

  // ==========================================================
  // Decode
  logic [5:0]       idx;
  logic [1:0]       mode;
  logic [DEV_W-1:0] curDev;
  logic [15:0]      curPtr;
  logic             reqSeen;
  logic             stsRead;
  logic             idleInc;

  assign idx     = address[7:2];
  assign mode    = s_reg.setup[`GPC_B_MODE_HI:`GPC_B_MODE_LO];
  assign curDev  = s_reg.setup[`GPC_B_DEV_HI:`GPC_B_DEV_LO];
  assign curPtr  = s_reg.ptr[curDev];
  assign reqSeen = (s_reg.st == gpc_pkg::ST_IDLE) && (read || write);
  assign stsRead = reqSeen && read && (idx == `GPC_IDX_STS);
  assign idleInc = phyStatus.rxErrorSym && phyStatus.rxIdle
                   && phyStatus.txModeSendN;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0]  be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic [15:0] wd;
    logic [7:0]  cntBase;
    logic        faultEv;
    logic        idleEv;
    wd      = writedata[15:0];
    cntBase = s_reg.idleCnt;
    faultEv = phyStatus.msFault;
    idleEv  = 1'b0;
    s_next  = s_reg;
    case (s_reg.st)
      gpc_pkg::ST_IDLE: begin
        if (read || write) begin
          if ((idx == `GPC_IDX_DATA) && (mode != `GPC_MODE_REG)) begin
            s_next.mmd.valid = 1'b1;
            s_next.mmd.write = write;
            s_next.mmd.dev   = curDev;
            s_next.mmd.addr  = curPtr;
            s_next.mmd.wdata = merge16(`GPC_ZERO16, wd, byteenable[1:0]);
            s_next.st        = gpc_pkg::ST_MMD;
          end else begin
            s_next.waitReq = 1'b0;
            s_next.st      = gpc_pkg::ST_RESP;
            s_next.rdata   = `GPC_ZERO16;
            if (read) begin
              case (idx)
                `GPC_IDX_CTRL:     s_next.rdata = s_reg.ctrl;
                `GPC_IDX_STS:      s_next.rdata = {s_reg.msFault,
                                                   phyStatus.resolvedMaster,
                                                   phyStatus.localRxOk,
                                                   phyStatus.remoteRxOk,
                                                   phyStatus.lpFullDuplex,
                                                   phyStatus.lpHalfDuplex,
                                                   2'b00,
                                                   s_reg.idleCnt};
                `GPC_IDX_SETUP:    s_next.rdata = s_reg.setup;
                `GPC_IDX_DATA:     s_next.rdata = curPtr;
                `GPC_IDX_IRQ_STS:  s_next.rdata = {14'h0000, s_reg.irqSts};
                `GPC_IDX_IRQ_MASK: s_next.rdata = {14'h0000, s_reg.irqMask};
                default:           s_next.rdata = `GPC_ZERO16;
              endcase
            end else begin
              case (idx)
                `GPC_IDX_CTRL: begin
                  s_next.ctrl = merge16(s_reg.ctrl, wd, byteenable[1:0])
                                & `GPC_CTRL_WMASK;
                end
                `GPC_IDX_SETUP: begin
                  s_next.setup = merge16(s_reg.setup, wd, byteenable[1:0]);
                end
                `GPC_IDX_DATA: begin
                  s_next.ptr[curDev] = merge16(curPtr, wd,
                                               byteenable[1:0]);
                end
                `GPC_IDX_IRQ_STS: begin
                  if (byteenable[0]) begin
                    s_next.irqSts = s_reg.irqSts & ~wd[1:0];
                  end
                end
                `GPC_IDX_IRQ_MASK: begin
                  if (byteenable[0]) begin
                    s_next.irqMask = wd[1:0];
                  end
                end
                default: begin
                  s_next.rdata = `GPC_ZERO16;
                end
              endcase
            end
          end
        end
      end
      gpc_pkg::ST_MMD: begin
        if (mmdRsp.ack) begin
          s_next.mmd.valid = 1'b0;
          s_next.waitReq   = 1'b0;
          s_next.st        = gpc_pkg::ST_RESP;
          s_next.rdata     = s_reg.mmd.write ? `GPC_ZERO16 : mmdRsp.rdata;
          if ((mode == `GPC_MODE_INCRW)
              || ((mode == `GPC_MODE_INCW) && s_reg.mmd.write)) begin
            s_next.ptr[curDev] = curPtr + `GPC_PTR_ONE;
          end
        end
      end
      gpc_pkg::ST_RESP: begin
        s_next.waitReq = 1'b1;
        s_next.st      = gpc_pkg::ST_IDLE;
      end
      default: begin
        s_next.waitReq = 1'b1;
        s_next.mmd     = '0;
        s_next.st      = gpc_pkg::ST_IDLE;
      end
    endcase

    // Fault latch and idle counter, events win over read clear
    s_next.msFault = (s_reg.msFault && !stsRead) || faultEv;
    if (stsRead) begin
      cntBase = '0;
    end
    if (idleInc && (cntBase != `GPC_IDLE_MAX)) begin
      cntBase = cntBase + `GPC_IDLE_ONE;
      idleEv  = 1'b1;
    end
    s_next.idleCnt = cntBase;

    // Interrupt status, set wins over write-one clear
    if (faultEv) begin
      s_next.irqSts[`GPC_IRQ_FAULT] = 1'b1;
    end
    if (idleEv) begin
      s_next.irqSts[`GPC_IRQ_IDLE] = 1'b1;
    end
    s_next.irq = |(s_next.irqSts & s_next.irqMask);

    // Settings to the PHY core track the control register
    s_next.phyCtrl.testMode   = s_next.ctrl[`GPC_B_TEST_HI:`GPC_B_TEST_LO];
    s_next.phyCtrl.roleManual = s_next.ctrl[`GPC_B_MANUAL];
    s_next.phyCtrl.roleMaster = s_next.ctrl[`GPC_B_MANUAL]
                                ? s_next.ctrl[`GPC_B_MVAL]
                                : s_next.ctrl[`GPC_B_PTYPE];
    s_next.phyCtrl.advFull    = s_next.ctrl[`GPC_B_ADVF];
    s_next.phyCtrl.advHalf    = s_next.ctrl[`GPC_B_ADVH];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= S_RST;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign readdata    = {`GPC_ZERO16, s_reg.rdata};
  assign waitrequest = s_reg.waitReq;
  assign phyCtrl     = s_reg.phyCtrl;
  assign mmdReq      = s_reg.mmd;
  assign irq         = s_reg.irq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  logic ctrlWr;
  assign ctrlWr = ce && reqSeen && write && (idx == `GPC_IDX_CTRL) && byteenable[1];

  a_role_enable_wr: assert property (ctrlWr |=>
    phyCtrl.roleManual == $past(writedata[`GPC_B_MANUAL]))
    else $error("manual role enable not taken from write");
  a_role_value_ign: assert property (
    (!s_reg.ctrl[`GPC_B_MANUAL] && $changed(s_reg.ctrl[`GPC_B_MVAL])
     && $stable(s_reg.ctrl[`GPC_B_PTYPE]) && $stable(s_reg.ctrl[`GPC_B_MANUAL]))
    |-> $stable(phyCtrl.roleMaster))
    else $error("role value acted while manual disabled");
  a_role_forced: assert property (phyCtrl.roleManual |->
    phyCtrl.roleMaster == s_reg.ctrl[`GPC_B_MVAL])
    else $error("manual role not forced");
  a_role_pref: assert property (!phyCtrl.roleManual |->
    phyCtrl.roleMaster == s_reg.ctrl[`GPC_B_PTYPE])
    else $error("port type preference not used");
  a_adv_full_wr: assert property (ctrlWr |=>
    phyCtrl.advFull == $past(writedata[`GPC_B_ADVF]))
    else $error("full duplex advert not updated");
  a_adv_half_wr: assert property (ctrlWr |=>
    phyCtrl.advHalf == $past(writedata[`GPC_B_ADVH]))
    else $error("half duplex advert not updated");
  a_fault_latch: assert property ((ce && phyStatus.msFault) |=>
    s_reg.msFault ##1 (s_reg.msFault || $past(stsRead && ce)))
    else $error("fault not latched");
  a_fault_clear: assert property ((ce && stsRead && !phyStatus.msFault)
    |=> !s_reg.msFault && readdata[`GPC_B_FAULT] == $past(s_reg.msFault))
    else $error("fault not cleared by read");
  a_role_status: assert property ((ce && stsRead) |=>
    readdata[`GPC_B_RES] == $past(phyStatus.resolvedMaster) && !waitrequest)
    else $error("resolved role not reported");
  a_idle_count: assert property (
    (ce && idleInc && !stsRead && s_reg.idleCnt != `GPC_IDLE_MAX)
    |=> s_reg.idleCnt == $past(s_reg.idleCnt) + `GPC_IDLE_ONE)
    else $error("idle error count did not step");
  a_idle_gate: assert property ((ce && !phyStatus.txModeSendN && !stsRead)
    |=> s_reg.idleCnt == $past(s_reg.idleCnt))
    else $error("idle errors counted outside normal send");
  a_mmd_target: assert property (mmdReq.valid |->
    mmdReq.dev == curDev && mmdReq.addr == curPtr)
    else $error("indirect access aimed wrongly");
  a_ptr_write: assert property ((ce && reqSeen && write && byteenable[1:0] == 2'h3
    && idx == `GPC_IDX_DATA && mode == `GPC_MODE_REG)
    |=> curPtr == $past(writedata[15:0]))
    else $error("pointer write lost");
  a_mmd_issue: assert property ((ce && reqSeen && idx == `GPC_IDX_DATA
    && mode != `GPC_MODE_REG) |=> mmdReq.valid && waitrequest)
    else $error("data access not issued");
  a_ptr_noinc: assert property ((ce && mmdReq.valid && mmdRsp.ack
    && mode == `GPC_MODE_NOINC) |=> $stable(curPtr))
    else $error("pointer moved in mode 01");
  a_ptr_inc_rw: assert property ((ce && mmdReq.valid && mmdRsp.ack
    && mode == `GPC_MODE_INCRW) |=> curPtr == $past(curPtr) + `GPC_PTR_ONE)
    else $error("pointer not advanced in mode 10");
  a_ptr_inc_w: assert property ((ce && mmdReq.valid && mmdRsp.ack
    && mode == `GPC_MODE_INCW) |=> curPtr == $past(curPtr)
    + ($past(mmdReq.write) ? `GPC_PTR_ONE : `GPC_ZERO16))
    else $error("pointer wrong in mode 11");

  // ==========================================================
  // Status word, interrupt, control, pointer and handshake checks
  a_fault_hold: assert property ((s_reg.msFault && !(ce && stsRead))
    |=> s_reg.msFault)
    else $error("fault dropped without a read");
  a_rx_status: assert property ((ce && stsRead) |=>
    readdata[`GPC_B_LRX] == $past(phyStatus.localRxOk)
    && readdata[`GPC_B_RRX] == $past(phyStatus.remoteRxOk))
    else $error("receiver status not reported");
  a_lp_ability: assert property ((ce && stsRead) |=>
    readdata[`GPC_B_LPF] == $past(phyStatus.lpFullDuplex)
    && readdata[`GPC_B_LPH] == $past(phyStatus.lpHalfDuplex))
    else $error("partner ability not reported");
  a_idle_clear: assert property ((ce && stsRead && !idleInc) |=>
    s_reg.idleCnt == `GPC_IDLE_ZERO
    && readdata[`GPC_B_CNT_HI:`GPC_B_CNT_LO] == $past(s_reg.idleCnt))
    else $error("idle error count not cleared by read");
  a_idle_sat: assert property ((ce && s_reg.idleCnt == `GPC_IDLE_MAX && !stsRead)
    |=> s_reg.idleCnt == `GPC_IDLE_MAX)
    else $error("idle error count wrapped");
  a_fault_irq: assert property ((ce && phyStatus.msFault)
    |=> s_reg.irqSts[`GPC_IRQ_FAULT])
    else $error("fault event not flagged");
  a_idle_irq: assert property ((ce && idleInc && s_reg.idleCnt != `GPC_IDLE_MAX)
    |=> s_reg.irqSts[`GPC_IRQ_IDLE])
    else $error("idle error not flagged");
  a_irq_level: assert property (irq == |(s_reg.irqSts & s_reg.irqMask))
    else $error("interrupt level wrong");
  a_wait_one: assert property ((ce && !waitrequest) |=> waitrequest)
    else $error("answer held longer than one cycle");
  a_test_mode: assert property (
    phyCtrl.testMode == s_reg.ctrl[`GPC_B_TEST_HI:`GPC_B_TEST_LO])
    else $error("test mode not passed on");
  a_ctrl_resv: assert property ((s_reg.ctrl & ~`GPC_CTRL_WMASK) == `GPC_ZERO16)
    else $error("reserved control bits set");
  a_mode_reg_local: assert property ((ce && reqSeen && idx == `GPC_IDX_DATA
    && mode == `GPC_MODE_REG) |=> !mmdReq.valid && !waitrequest)
    else $error("pointer access went to a device");
  a_ptr_read: assert property ((ce && reqSeen && read && idx == `GPC_IDX_DATA
    && mode == `GPC_MODE_REG) |=> readdata == {`GPC_ZERO16, $past(curPtr)})
    else $error("pointer read wrong");
  a_mmd_hold: assert property ((mmdReq.valid && !mmdRsp.ack) |=>
    mmdReq.valid && $stable(mmdReq))
    else $error("device request changed before ack");
  a_data_read: assert property ((ce && mmdReq.valid && mmdRsp.ack && !mmdReq.write)
    |=> readdata == {`GPC_ZERO16, $past(mmdRsp.rdata)} && !waitrequest)
    else $error("device read data not returned");

  c_fault_read: cover property (s_reg.msFault ##[1:20] stsRead);
  c_mmd_incr: cover property (mmdReq.valid && mmdRsp.ack && mode == `GPC_MODE_INCRW);
  c_irq_rise: cover property ($rose(irq));
  c_idle_sat: cover property (s_reg.idleCnt == `GPC_IDLE_MAX);
  c_role_manual: cover property (phyCtrl.roleManual && phyCtrl.roleMaster);
endmodule // gpc_regs
